// File: hdl/iad_pkg.sv
// Shared constants, codes and state types of the I/O processor ALU and bus datapath.
package iad_pkg;

   // ==========================================================
   // Widths and sizes
   localparam int DATA_W = 16;
   localparam int REG_N = 16;
   localparam int SEL_W = 4;
   localparam int DISP_W = 8;
   localparam int JAR_W = 8;
   localparam int AXI_AW = 8;

   // ==========================================================
   // Arithmetic unit operation codes
   typedef enum logic [3:0] {
      op_none = 4'h0,
      op_copy_bus_to_reg = 4'h1,
      op_add_bus_to_reg = 4'h2,
      op_and_bus_with_reg = 4'h3,
      op_or_bus_with_reg = 4'h4,
      op_xor_bus_with_reg = 4'h5,
      op_route_bus_through = 4'h6,
      op_route_first_reg = 4'h7,
      op_bump_second_reg_up = 4'h8,
      op_bump_second_reg_down = 4'h9,
      op_bump_bus_up = 4'ha,
      op_bump_bus_down = 4'hb,
      op_add_regs = 4'hc,
      op_sub_regs = 4'hd,
      op_route_second_reg = 4'he,
      op_route_aux_reg = 4'hf
   } iad_op_t;

   // ==========================================================
   // Transfer source, destination and special codes
   typedef enum logic [2:0] {
      SRC_ALU = 3'h0, SRC_DISP = 3'h1, SRC_FIB = 3'h2, SRC_IOR = 3'h3,
      SRC_PAC = 3'h4, SRC_CR = 3'h6, SRC_SPECIAL = 3'h7
   } iad_src_t;
   typedef enum logic [2:0] {
      DST_NONE = 3'h0, DST_FOB = 3'h2, DST_IOR = 3'h3, DST_JAR = 3'h4, DST_CR = 3'h6
   } iad_dst_t;
   localparam int SPECIAL_TRANSFER_FIELD_W = 3;
   localparam logic [SPECIAL_TRANSFER_FIELD_W-1:0] SPECIAL_TRANSFER_FIELD_PM_TO_IOR = 3'h0;
   localparam logic [SPECIAL_TRANSFER_FIELD_W-1:0] SPECIAL_TRANSFER_FIELD_IOR_TO_PM = 3'h1;

   // ==========================================================
   // Special transfer sequencer states, one-hot
   typedef enum logic [2:0] {
      FSM_IDLE = 3'b001, FSM_PM_READ = 3'b010, FSM_PM_WRITE = 3'b100
   } iad_fsm_t;

   // ==========================================================
   // Register map of the AXI4-Lite slave, byte addresses
   localparam logic [AXI_AW-1:0] REG_ALU_Y = 8'h00;
   localparam logic [AXI_AW-1:0] REG_BUS = 8'h04;
   localparam logic [AXI_AW-1:0] REG_AUX_Q = 8'h08;
   localparam logic [AXI_AW-1:0] REG_IOR = 8'h0c;
   localparam logic [AXI_AW-1:0] REG_CTRL = 8'h10;
   localparam logic [AXI_AW-1:0] REG_STATUS = 8'h14;
   localparam int STAT_BUSY_BIT = 8;
   localparam int STAT_DRIVEN_BIT = 9;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: hdl/iad_regfile.sv
// Sixteen-entry general register file with two read ports and one write port.
`timescale 1ns/1ps
module iad_regfile #(
   parameter int W = iad_pkg::DATA_W,
   parameter int N = iad_pkg::REG_N
) (
   input wire logic clk, // Clock.
   input wire logic rst, // Synchronous reset, high.
   input wire logic [$clog2(N)-1:0] sel_a, // First operand select.
   input wire logic [$clog2(N)-1:0] sel_b, // Second operand and result select.
   input wire logic we, // Write the result into the second register.
   input wire logic [W-1:0] wdata, // Result to write.
   output logic [W-1:0] rd_a, // First operand.
   output logic [W-1:0] rd_b // Second operand.
);
   typedef struct packed {
      logic [N-1:0][W-1:0] r;
   } iad_rf_st_t;

   iad_rf_st_t st_q;
   iad_rf_st_t st_d;
   logic [N-1:0][W-1:0] nxt;

   // ==========================================================
   // Per-entry next value; a write lands at the cycle's end only.
   for (genvar i = 0; i < N; i++) begin : g_ent
      assign nxt[i] = (we && sel_b == ($clog2(N))'(i)) ? wdata : st_q.r[i];
   end

   // Reads see the values held before this cycle's write.
   assign rd_a = st_q.r[sel_a];
   assign rd_b = st_q.r[sel_b];

   // Next-state copy.
   always_comb begin
      st_d.r = nxt;
   end

   // State register.
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // iad_regfile

// File: hdl/iad_alu.sv
// Combinational arithmetic unit: operation decode, result and write enable.
`timescale 1ns/1ps
module iad_alu #(
   parameter int W = iad_pkg::DATA_W
) (
   input wire logic [3:0] op, // Operation code.
   input wire logic [W-1:0] a, // First register operand.
   input wire logic [W-1:0] b, // Second register operand.
   input wire logic [W-1:0] d, // Data bus operand.
   input wire logic [W-1:0] q, // Auxiliary register.
   output logic [W-1:0] y, // Arithmetic unit output.
   output logic wr_b // Result goes back to the second register.
);
   localparam logic [W-1:0] ONE = W'(1);

   // ==========================================================
   // One case over all sixteen codes; sums wrap at the data width.
   always_comb begin
      y = '0;
      wr_b = 1'b0;
      case (op)
         iad_pkg::op_copy_bus_to_reg: begin y = d; wr_b = 1'b1; end
         iad_pkg::op_add_bus_to_reg: begin y = d + a; wr_b = 1'b1; end
         iad_pkg::op_and_bus_with_reg: begin y = d & a; wr_b = 1'b1; end
         iad_pkg::op_or_bus_with_reg: begin y = d | a; wr_b = 1'b1; end
         iad_pkg::op_xor_bus_with_reg: begin y = d ^ a; wr_b = 1'b1; end
         iad_pkg::op_route_bus_through: y = d;
         // B is not written, since the write enable stays low, so it keeps its value.
         iad_pkg::op_route_first_reg: y = a;
         iad_pkg::op_bump_second_reg_up: begin y = b + ONE; wr_b = 1'b1; end
         iad_pkg::op_bump_second_reg_down: begin y = b - ONE; wr_b = 1'b1; end
         iad_pkg::op_bump_bus_up: y = d + ONE;
         iad_pkg::op_bump_bus_down: y = d - ONE;
         iad_pkg::op_add_regs: begin y = a + b; wr_b = 1'b1; end
         iad_pkg::op_sub_regs: begin y = b - a; wr_b = 1'b1; end
         iad_pkg::op_route_second_reg: y = b;
         iad_pkg::op_route_aux_reg: y = q;
         default: begin y = '0; wr_b = 1'b0; end
      endcase
   end
endmodule // iad_alu

// File: hdl/iad_datapath.sv
// Top of the I/O processor datapath: transfer decode, bus, registers and AXI4-Lite slave.
// Contract
// - Fields A and B each select one of sixteen general registers.
// - Code 1 copies bus into B and outputs it.
// - Code 2 adds bus to A, writes B, outputs sum.
// - Codes 3, 4, 5: bus AND, OR, XOR A into B and out.
// - Code 6 passes bus to output, stores nothing.
// - Code 7 outputs A; B keeps its value.
// - Codes 10, 11 octal: B plus or minus one, written and output.
// - Codes 12, 13 octal output bus plus or minus one, unsaved.
// - Code 14 octal: A plus B into B and out.
// - Code 15 octal: B minus A into B and out.
// - Code 16 outputs B; code 17 outputs auxiliary Q.
// - Sources 0, 1, 2: arithmetic output, displacement, FIFO input buffer.
// - Sources 3, 4, 6: I/O register, address counter, control register.
// - Source 7 drops normal transfer and decodes the special field.
// - Destination 0 loads nothing; 2 and 3 load output buffer, I/O register.
// - Destinations 4 and 6 load jump address and control registers.
// - Special 0 copies program memory word into I/O register, two cycles.
// - Special 1 writes I/O register into program memory, two cycles.
// - Source drives from cycle start; destination captures at cycle end.
// - Jump address register takes only the low eight bus bits.
`timescale 1ns/1ps
module iad_datapath #(
   parameter int W = iad_pkg::DATA_W
) (
   input wire logic CLK, // Clock, 20 MHz.
   input wire logic RST, // Synchronous reset, high.
   input wire logic INSTR_VALID, // An instruction word is offered this cycle.
   output logic BUSY, // Second cycle of a special transfer; hold the word.
   input wire logic [iad_pkg::SEL_W-1:0] A_SEL, // First register select.
   input wire logic [iad_pkg::SEL_W-1:0] B_SEL, // Second register select.
   input wire logic [3:0] ALU_OP, // Arithmetic operation code.
   input wire logic [2:0] XFER_SRC, // Transfer source code.
   input wire logic [2:0] XFER_DST, // Transfer destination code.
   input wire logic [iad_pkg::SPECIAL_TRANSFER_FIELD_W-1:0] SPECIAL_TRANSFER_FIELD, // Special code.
   input wire logic [iad_pkg::DISP_W-1:0] EIGHT_BIT_DISPLACEMENT_FIELD, // Immediate.
   input wire logic [W-1:0] FIFO_INPUT_BUFFER, // Word at the FIFO head.
   input wire logic [W-1:0] PROGRAM_ADDRESS_COUNTER, // Sequencer address.
   input wire logic [W-1:0] PROGRAM_MEMORY_WORD, // Program memory read data.
   output logic PM_RD, // Program memory read cycle.
   output logic PM_WR, // Program memory write strobe.
   output logic [W-1:0] PM_WDATA, // Program memory write data.
   output logic [W-1:0] FIFO_OUTPUT_BUFFER, // Word for the output FIFO.
   output logic FOB_LOAD, // One-cycle pulse: output buffer loaded.
   output logic [W-1:0] IO_HOLDING_REGISTER, // I/O holding register.
   output logic [W-1:0] CONTROL_REGISTER, // Control register.
   output logic [iad_pkg::JAR_W-1:0] JUMP_ADDRESS_REGISTER, // Jump target.
   output logic JAR_LOAD, // One-cycle pulse: jump address loaded.
   output logic [W-1:0] ALU_Y, // Last arithmetic output.
   output logic [W-1:0] SHARED_DATA_BUS, // Last bus value.
   output logic BUS_DRIVEN, // Last bus had a source.
   input wire logic [iad_pkg::AXI_AW-1:0] S_AXI_AWADDR, // Write address.
   input wire logic S_AXI_AWVALID, // Write address valid.
   output logic S_AXI_AWREADY, // Write address ready.
   input wire logic [31:0] S_AXI_WDATA, // Write data.
   input wire logic [3:0] S_AXI_WSTRB, // Write strobes.
   input wire logic S_AXI_WVALID, // Write data valid.
   output logic S_AXI_WREADY, // Write data ready.
   output logic [1:0] S_AXI_BRESP, // Write response.
   output logic S_AXI_BVALID, // Write response valid.
   input wire logic S_AXI_BREADY, // Write response ready.
   input wire logic [iad_pkg::AXI_AW-1:0] S_AXI_ARADDR, // Read address.
   input wire logic S_AXI_ARVALID, // Read address valid.
   output logic S_AXI_ARREADY, // Read address ready.
   output logic [31:0] S_AXI_RDATA, // Read data.
   output logic [1:0] S_AXI_RRESP, // Read response.
   output logic S_AXI_RVALID, // Read data valid.
   input wire logic S_AXI_RREADY // Read data ready.
);

   // ==========================================================
   // Elaboration checks
   if (W < iad_pkg::DISP_W || W > 32) begin : g_bad_w
      $error("Data width must lie between the displacement width and 32.");
   end

   // ==========================================================
   // State
   typedef struct packed {
      iad_pkg::iad_fsm_t fsm;
      logic [W-1:0] io_holding_register;
      logic [W-1:0] cr;
      logic [iad_pkg::JAR_W-1:0] jar;
      logic jar_ld;
      logic [W-1:0] q;
      logic [W-1:0] y;
      logic [W-1:0] db;
      logic db_drv;
      logic [W-1:0] fob;
      logic fob_ld;
      logic aw_ok;
      logic [iad_pkg::AXI_AW-1:0] awaddr;
      logic w_ok;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } iad_st_t;

   iad_st_t st_q;
   iad_st_t st_d;

   logic go;
   logic [W-1:0] rd_a;
   logic [W-1:0] rd_b;
   logic [W-1:0] y;
   logic alu_wr;
   logic [W-1:0] src_bus;
   logic src_drv;
   logic [W-1:0] bus;
   logic bus_drv;
   logic special;

   // ==========================================================
   // Register map helpers
   function automatic logic known_addr(input logic [iad_pkg::AXI_AW-1:0] ad);
      known_addr = (ad == iad_pkg::REG_ALU_Y) || (ad == iad_pkg::REG_BUS) ||
         (ad == iad_pkg::REG_AUX_Q) || (ad == iad_pkg::REG_IOR) ||
         (ad == iad_pkg::REG_CTRL) || (ad == iad_pkg::REG_STATUS);
   endfunction

   function automatic logic [31:0] widen(input logic [W-1:0] v);
      logic [31:0] t;
      t = '0;
      t[W-1:0] = v;
      widen = t;
   endfunction

   // ==========================================================
   // An instruction is taken only while no special transfer is in its second cycle.
   assign go = INSTR_VALID && (st_q.fsm == iad_pkg::FSM_IDLE);
   assign special = (XFER_SRC == iad_pkg::SRC_SPECIAL);

   // ==========================================================
   // Register file and arithmetic unit.
   iad_regfile #(.W(W), .N(iad_pkg::REG_N)) u_rf (
      .clk(CLK),
      .rst(RST),
      .sel_a(A_SEL),
      .sel_b(B_SEL),
      .we(go && alu_wr),
      .wdata(y),
      .rd_a(rd_a),
      .rd_b(rd_b)
   );

   iad_alu #(.W(W)) u_alu (
      .op(ALU_OP),
      .a(rd_a),
      .b(rd_b),
      .d(src_bus),
      .q(st_q.q),
      .y(y),
      .wr_b(alu_wr)
   );

   // ==========================================================
   // Non-arithmetic bus sources. The arithmetic unit reads only these, so
   // when it is itself the source its bus operand is zero; this breaks
   // the loop that the unit would otherwise form through the bus.
   always_comb begin
      src_bus = '0;
      src_drv = 1'b1;
      case (XFER_SRC)
         iad_pkg::SRC_DISP: src_bus = W'(EIGHT_BIT_DISPLACEMENT_FIELD);
         iad_pkg::SRC_FIB: src_bus = FIFO_INPUT_BUFFER;
         iad_pkg::SRC_IOR: src_bus = st_q.io_holding_register;
         iad_pkg::SRC_PAC: src_bus = PROGRAM_ADDRESS_COUNTER;
         iad_pkg::SRC_CR: src_bus = st_q.cr;
         default: src_drv = 1'b0;
      endcase
   end

   // The source drives for the whole cycle; arithmetic output is source 0.
   assign bus = (XFER_SRC == iad_pkg::SRC_ALU) ? y : src_bus;
   assign bus_drv = (XFER_SRC == iad_pkg::SRC_ALU) || src_drv;

   // ==========================================================
   // Handshake outputs.
   assign BUSY = (st_q.fsm != iad_pkg::FSM_IDLE);
   assign PM_RD = (st_q.fsm == iad_pkg::FSM_PM_READ);
   assign PM_WR = (st_q.fsm == iad_pkg::FSM_PM_WRITE);
   assign S_AXI_AWREADY = !st_q.aw_ok && !st_q.bvalid;
   assign S_AXI_WREADY = !st_q.w_ok && !st_q.bvalid;
   assign S_AXI_ARREADY = !st_q.rvalid;

   // Registered data outputs.
   assign PM_WDATA = st_q.io_holding_register;
   assign FIFO_OUTPUT_BUFFER = st_q.fob;
   assign FOB_LOAD = st_q.fob_ld;
   assign IO_HOLDING_REGISTER = st_q.io_holding_register;
   assign CONTROL_REGISTER = st_q.cr;
   assign JUMP_ADDRESS_REGISTER = st_q.jar;
   assign JAR_LOAD = st_q.jar_ld;
   assign ALU_Y = st_q.y;
   assign SHARED_DATA_BUS = st_q.db;
   assign BUS_DRIVEN = st_q.db_drv;
   assign S_AXI_BVALID = st_q.bvalid;
   assign S_AXI_BRESP = st_q.bresp;
   assign S_AXI_RVALID = st_q.rvalid;
   assign S_AXI_RDATA = st_q.rdata;
   assign S_AXI_RRESP = st_q.rresp;

   // ==========================================================
   // Next state: instruction execution, special transfers and bus slave.
   always_comb begin
      logic [31:0] qw;
      qw = '0;
      st_d = st_q;
      st_d.fob_ld = 1'b0;
      st_d.jar_ld = 1'b0;

      // Destinations capture the bus at the end of the taken cycle.
      if (go) begin
         st_d.y = y;
         st_d.db = bus_drv ? bus : '0;
         st_d.db_drv = bus_drv;
         if (special) begin
            case (SPECIAL_TRANSFER_FIELD)
               iad_pkg::SPECIAL_TRANSFER_FIELD_PM_TO_IOR: st_d.fsm = iad_pkg::FSM_PM_READ;
               iad_pkg::SPECIAL_TRANSFER_FIELD_IOR_TO_PM: st_d.fsm = iad_pkg::FSM_PM_WRITE;
               default: st_d.fsm = iad_pkg::FSM_IDLE;
            endcase
         end else begin
            case (XFER_DST)
               iad_pkg::DST_FOB: begin
                  st_d.fob = bus;
                  st_d.fob_ld = 1'b1;
               end
               iad_pkg::DST_IOR: st_d.io_holding_register = bus;
               iad_pkg::DST_JAR: begin
                  st_d.jar = bus[iad_pkg::JAR_W-1:0];
                  st_d.jar_ld = 1'b1;
               end
               iad_pkg::DST_CR: st_d.cr = bus;
               default: st_d.fob_ld = 1'b0;
            endcase
         end
      end

      // Second cycle of a special transfer; no new word is taken meanwhile.
      case (st_q.fsm)
         iad_pkg::FSM_IDLE: st_d.fsm = st_d.fsm;
         iad_pkg::FSM_PM_READ: begin
            st_d.io_holding_register = PROGRAM_MEMORY_WORD;
            st_d.fsm = iad_pkg::FSM_IDLE;
         end
         iad_pkg::FSM_PM_WRITE: st_d.fsm = iad_pkg::FSM_IDLE;
         default: st_d.fsm = iad_pkg::FSM_IDLE;
      endcase

      // Write channel: address and data are taken in either order.
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         st_d.aw_ok = 1'b1;
         st_d.awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         st_d.w_ok = 1'b1;
         st_d.wdata = S_AXI_WDATA;
         st_d.wstrb = S_AXI_WSTRB;
      end
      // Only Q is writable; the other words belong to the instruction stream,
      // and letting software write them would race the datapath.
      if (st_q.aw_ok && st_q.w_ok) begin
         st_d.aw_ok = 1'b0;
         st_d.w_ok = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = known_addr(st_q.awaddr) ? iad_pkg::RESP_OKAY : iad_pkg::RESP_SLVERR;
         if (st_q.awaddr == iad_pkg::REG_AUX_Q) begin
            qw = widen(st_q.q);
            for (int i = 0; i < 4; i++) begin
               if (st_q.wstrb[i]) begin
                  qw[8*i +: 8] = st_q.wdata[8*i +: 8];
               end
            end
            st_d.q = qw[W-1:0];
         end
      end else if (st_q.bvalid && S_AXI_BREADY) begin
         st_d.bvalid = 1'b0;
      end

      // Read channel: data appears one cycle after the address is taken.
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         st_d.rvalid = 1'b1;
         st_d.rresp = known_addr(S_AXI_ARADDR) ? iad_pkg::RESP_OKAY : iad_pkg::RESP_SLVERR;
         case (S_AXI_ARADDR)
            iad_pkg::REG_ALU_Y: st_d.rdata = widen(st_q.y);
            iad_pkg::REG_BUS: st_d.rdata = widen(st_q.db);
            iad_pkg::REG_AUX_Q: st_d.rdata = widen(st_q.q);
            iad_pkg::REG_IOR: st_d.rdata = widen(st_q.io_holding_register);
            iad_pkg::REG_CTRL: st_d.rdata = widen(st_q.cr);
            iad_pkg::REG_STATUS: begin
               st_d.rdata = '0;
               st_d.rdata[iad_pkg::JAR_W-1:0] = st_q.jar;
               st_d.rdata[iad_pkg::STAT_BUSY_BIT] = BUSY;
               st_d.rdata[iad_pkg::STAT_DRIVEN_BIT] = st_q.db_drv;
            end
            default: st_d.rdata = '0;
         endcase
      end else if (st_q.rvalid && S_AXI_RREADY) begin
         st_d.rvalid = 1'b0;
      end
   end

   // ==========================================================
   // State register.
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_q <= '0;
         st_q.fsm <= iad_pkg::FSM_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

endmodule // iad_datapath

// File: tb/iad_datapath_chk.sv
// Concurrent checks on the ports of the I/O processor datapath.
`timescale 1ns/1ps
module iad_datapath_chk #(
   parameter int W = 16
) (
   input wire logic CLK, // Clock.
   input wire logic RST, // Reset.
   input wire logic INSTR_VALID, // Word offered.
   input wire logic BUSY, // Special second cycle.
   input wire logic [3:0] ALU_OP, // Operation.
   input wire logic [2:0] XFER_SRC, // Source code.
   input wire logic [2:0] XFER_DST, // Destination code.
   input wire logic [2:0] SPECIAL_TRANSFER_FIELD, // Special code.
   input wire logic [W-1:0] FIFO_INPUT_BUFFER, // FIFO head.
   input wire logic [W-1:0] PROGRAM_MEMORY_WORD, // Memory data.
   input wire logic PM_RD, // Memory read.
   input wire logic PM_WR, // Memory write.
   input wire logic [W-1:0] PM_WDATA, // Memory write data.
   input wire logic [W-1:0] FIFO_OUTPUT_BUFFER, // Output buffer.
   input wire logic FOB_LOAD, // Buffer loaded.
   input wire logic [W-1:0] IO_HOLDING_REGISTER, // I/O register.
   input wire logic [7:0] JUMP_ADDRESS_REGISTER, // Jump target.
   input wire logic JAR_LOAD, // Jump loaded.
   input wire logic [W-1:0] ALU_Y, // Arithmetic output.
   input wire logic [W-1:0] SHARED_DATA_BUS // Bus value.
);
   // ==========================================================
   // A word counts only when no special transfer holds the port.
   logic tk;
   assign tk = INSTR_VALID && !BUSY;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   chk_special_transfer_field_read: assert property (tk && XFER_SRC == 3'h7 && SPECIAL_TRANSFER_FIELD == 3'h0
      |=> BUSY && PM_RD ##1 !BUSY) else $error("special read sequence wrong");
   chk_pm_load: assert property (PM_RD |=> IO_HOLDING_REGISTER == $past(PROGRAM_MEMORY_WORD))
      else $error("memory word not in io register");
   chk_special_transfer_field_write: assert property (tk && XFER_SRC == 3'h7 && SPECIAL_TRANSFER_FIELD == 3'h1
      |=> PM_WR && BUSY && PM_WDATA == IO_HOLDING_REGISTER) else $error("special write wrong");
   chk_refuse_busy: assert property (BUSY |=> $stable(ALU_Y)) else $error("word taken while busy");
   chk_fob_load: assert property (tk && XFER_SRC != 3'h7 && XFER_DST == 3'h2
      |=> FOB_LOAD && FIFO_OUTPUT_BUFFER == SHARED_DATA_BUS) else $error("output buffer load");
   chk_jar_low: assert property (tk && XFER_SRC != 3'h7 && XFER_DST == 3'h4
      |=> JAR_LOAD && JUMP_ADDRESS_REGISTER == SHARED_DATA_BUS[7:0]) else $error("jump load");
   chk_fifo_src: assert property (tk && XFER_SRC == 3'h2
      |=> SHARED_DATA_BUS == $past(FIFO_INPUT_BUFFER)) else $error("fifo not on bus");
   chk_route_bus: assert property (tk && ALU_OP == 4'h6 && XFER_SRC inside {3'h1, 3'h2}
      |=> ALU_Y == SHARED_DATA_BUS) else $error("bus not routed to output");
endmodule // iad_datapath_chk
bind iad_datapath iad_datapath_chk #(.W(W)) chk_i (.*);

// File: tb/iad_far_model.sv
// Program memory, FIFO head and sequencer address seen from the datapath.
`timescale 1ns/1ps
module iad_far_model (
   input wire logic clk, // Clock.
   input wire logic pm_rd, // Memory read cycle.
   input wire logic pm_wr, // Memory write strobe.
   input wire logic [15:0] pm_wdata, // Write data.
   output logic [15:0] pm_word, // Read data.
   output logic [15:0] fifo_head, // FIFO head word.
   output logic [15:0] pac // Sequencer address.
);
   // ==========================================================
   // Outside a read cycle the data lines show junk, so a late sample is caught.
   logic [15:0] mem_q = 16'h5a3c;
   assign pm_word = pm_rd ? mem_q : ~mem_q;
   assign fifo_head = 16'hbeef;
   assign pac = 16'h0123;
   // One memory word stands for the location the sequencer addresses.
   always @(posedge clk) if (pm_wr) mem_q <= pm_wdata;
endmodule // iad_far_model

// File: tb/iad_datapath_tb.sv
// Self-checking bench of the I/O processor datapath.
`timescale 1ns/1ps
module iad_datapath_tb;
   typedef struct packed {
      logic [3:0] op;
      logic [3:0] a;
      logic [3:0] b;
      logic [2:0] s;
      logic [2:0] t;
      logic [7:0] d;
      logic [15:0] y;
   } iad_row_t;
   logic CLK, RST, INSTR_VALID, BUSY, PM_RD, PM_WR, FOB_LOAD, JAR_LOAD, BUS_DRIVEN;
   logic [3:0] A_SEL, B_SEL, ALU_OP, S_AXI_WSTRB;
   logic [2:0] XFER_SRC, XFER_DST, SPECIAL_TRANSFER_FIELD;
   logic [7:0] EIGHT_BIT_DISPLACEMENT_FIELD, JUMP_ADDRESS_REGISTER, S_AXI_AWADDR, S_AXI_ARADDR;
   logic [15:0] FIFO_INPUT_BUFFER, PROGRAM_ADDRESS_COUNTER, PROGRAM_MEMORY_WORD, PM_WDATA;
   logic [15:0] FIFO_OUTPUT_BUFFER, IO_HOLDING_REGISTER, CONTROL_REGISTER, ALU_Y, SHARED_DATA_BUS;
   logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
   logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   int fail_count = 0;
   int tests_run = 0;
   // Rows run in order; later rows lean on register values the earlier rows left.
   iad_row_t rows [26] = '{'{1,0,1,1,0,'h05,'h0005}, '{1,0,2,1,0,'h03,'h0003},
      '{2,1,3,1,0,'h10,'h0015}, '{3,1,4,1,0,'h0f,'h0005}, '{4,2,4,1,0,'h08,'h000b},
      '{5,1,4,1,0,'h0f,'h000a}, '{6,1,1,1,3,'h77,'h0077}, '{7,3,1,1,0,'h00,'h0015},
      '{8,0,1,1,0,0,'h0006}, '{9,0,2,1,0,0,'h0002}, '{'ha,0,0,1,6,'hff,'h0100},
      '{'hb,0,0,1,2,'h00,'hffff}, '{'hc,2,1,1,0,0,'h0008}, '{'hd,2,1,1,0,0,'h0006},
      '{'he,0,1,1,0,0,'h0006}, '{'hf,0,0,1,0,0,'h1234}, '{0,1,1,1,0,'h44,0},
      '{'he,0,1,5,7,0,'h0006}, '{7,3,0,0,4,0,'h0015}, '{6,0,0,2,0,0,'hbeef},
      '{6,0,0,3,0,0,'h0077}, '{6,0,0,4,0,0,'h0123}, '{6,0,0,6,0,0,'h00ff},
      '{6,0,0,5,0,0,'h0000}, '{2,4,4,1,0,'h01,'h000b}, '{'he,0,4,1,0,0,'h000b}};
   iad_datapath uut (.*);
   iad_far_model far (.clk(CLK), .pm_rd(PM_RD), .pm_wr(PM_WR), .pm_wdata(PM_WDATA),
      .pm_word(PROGRAM_MEMORY_WORD), .fifo_head(FIFO_INPUT_BUFFER), .pac(PROGRAM_ADDRESS_COUNTER));
   // ==========================================================
   // Clock, 50 ns period.
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic put(input iad_row_t r);
      ALU_OP <= r.op;
      A_SEL <= r.a;
      B_SEL <= r.b;
      XFER_SRC <= r.s;
      XFER_DST <= r.t;
      EIGHT_BIT_DISPLACEMENT_FIELD <= r.d;
      INSTR_VALID <= 1'b1;
   endtask
   // Holds the word until an edge with BUSY low has taken it.
   task automatic issue(input iad_row_t r);
      logic bz;
      @(posedge CLK);
      put(r);
      do begin
         @(negedge CLK);
         bz = BUSY;
         @(posedge CLK);
      end while (bz !== 1'b0);
      INSTR_VALID <= 1'b0;
      @(negedge CLK);
   endtask
   // One register access; each channel is released at the edge that takes it.
   task automatic axi(input bit wr, input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
      @(posedge CLK);
      if (wr) begin
         S_AXI_AWADDR <= ad;
         S_AXI_WDATA <= dt;
         S_AXI_AWVALID <= 1'b1;
         S_AXI_WVALID <= 1'b1;
         S_AXI_BREADY <= 1'b1;
      end else begin
         S_AXI_ARADDR <= ad;
         S_AXI_ARVALID <= 1'b1;
         S_AXI_RREADY <= 1'b1;
      end
      do begin
         @(posedge CLK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            cmp("BRESP", 32'(er), 32'(S_AXI_BRESP));
            S_AXI_BREADY <= 1'b0;
         end
         if (S_AXI_RVALID && S_AXI_RREADY) begin
            cmp("RRESP", 32'(er), 32'(S_AXI_RRESP));
            cmp("RDATA", dt, S_AXI_RDATA);
            S_AXI_RREADY <= 1'b0;
         end
      end while (S_AXI_BREADY || S_AXI_RREADY);
   endtask
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog: the whole run needs under a hundred cycles.
   initial begin
      repeat (3000) @(posedge CLK);
      fail_count++;
      give_verdict();
   end
   // Main sequence.
   initial begin
      {RST, INSTR_VALID, A_SEL, B_SEL, ALU_OP, XFER_SRC, XFER_DST} = {1'b1, 21'h0};
      {SPECIAL_TRANSFER_FIELD, EIGHT_BIT_DISPLACEMENT_FIELD, S_AXI_AWADDR, S_AXI_ARADDR} = 27'h0;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
      {S_AXI_WDATA, S_AXI_WSTRB} = {32'h0, 4'hf};
      repeat (3) @(posedge CLK);
      RST <= 1'b0;
      @(negedge CLK);
      cmp("ALU_Y", 32'h0, 32'(ALU_Y));
      cmp("BUSY", 32'h0, 32'(BUSY));
      $display("Reset test done");
      axi(1'b1, iad_pkg::REG_AUX_Q, 32'hcafe1234, iad_pkg::RESP_OKAY);
      axi(1'b1, 8'h40, 32'h0, iad_pkg::RESP_SLVERR);
      axi(1'b0, iad_pkg::REG_AUX_Q, 32'h00001234, iad_pkg::RESP_OKAY);
      axi(1'b0, 8'h40, 32'h0, iad_pkg::RESP_SLVERR);
      $display("Register access test done");
      foreach (rows[i]) begin
         issue(rows[i]);
         if (rows[i].op != 4'h0) cmp("ALU_Y", 32'(rows[i].y), 32'(ALU_Y));
      end
      $display("Operation table test done");
      SPECIAL_TRANSFER_FIELD <= 3'h1;
      issue('{4'he, 0, 1, 7, 0, 0, 0});
      cmp("PM_WDATA", 32'h77, PM_WR ? 32'(PM_WDATA) : 32'hdead);
      issue('{6, 0, 0, 1, 3, 'h11, 0});
      @(posedge CLK);
      SPECIAL_TRANSFER_FIELD <= 3'h0;
      put('{4'he, 0, 1, 7, 0, 0, 0});
      @(posedge CLK);
      put('{6, 0, 0, 1, 0, 'h55, 0});
      @(negedge CLK);
      cmp("PM_RD", 32'h1, 32'({BUSY, PM_RD} == 2'b11));
      @(negedge CLK);
      cmp("IO_HOLDING_REGISTER", 32'h0077, 32'(IO_HOLDING_REGISTER));
      cmp("ALU_Y", 32'h0006, 32'(ALU_Y));
      @(posedge CLK);
      INSTR_VALID <= 1'b0;
      @(negedge CLK);
      cmp("ALU_Y", 32'h0055, 32'(ALU_Y));
      axi(1'b0, iad_pkg::REG_CTRL, 32'h000000ff, iad_pkg::RESP_OKAY);
      axi(1'b0, iad_pkg::REG_STATUS, 32'h00000215, iad_pkg::RESP_OKAY);
      $display("Special transfer test done");
      give_verdict();
   end
endmodule // iad_datapath_tb
